//--- src/instr_sync_packet_builder.sv
// Instruction-sync packet builder with classic Wishbone register slave
`timescale 1ns/1ps
// Notes on behaviour
// - Zero to four context bytes per packet, count from control bits 15:14.
// - Info byte bit 7 is 0 for plain, 1 for load/store form.
// - Info byte bits 6:5 carry the reason code.
// - Info byte bit 4 set when in bytecode state.
// - Info byte bit 3 set when in non-secure state.
// - Info byte bit 2 is the alternative set flag when enabled, else zero.
// - Info byte bit 1 is the hypervisor flag when enabled, else zero.
// - Plain forms always carry four full uncompressed address bytes.
// - Address bit 0 carries the halfword set flag.
// - State decode from bytecode, halfword and alternative flags, two patterns reserved.
// - In bytecode state address bit 0 carries the true address bit.
// - Count form is plain packet plus wait-atom count since last atom header.
// - Count form never used with the periodic reason.
// - With overflow reason the count is unreliable and receiver ignores it.
// - Count byte continuation bit is 1 except on the last byte.
// - Load/store form only when trace starts mid data access with another executing.
// - Load/store form never used with the periodic reason.
// - Load/store form carries the data instruction address, implied executed.
// - Current address compressed to one to five bytes, branch style, no vector form.
// - Compression is relative to the data instruction address.
// - Compressed address grows to six bytes on a security change, in the load/store form only.
// - Mid data, retired, nothing executing: plain packet with data address, then branch.
// - Cycle-accurate non-periodic packets carry an embedded count.
// - Reason codes: periodic, trace on, overflow restart, debug exit.
module instr_sync_packet_builder (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic req_valid,
    input wire isync_pkg::sync_req_s req,
    output logic req_ready,
    output logic out_valid,
    output isync_pkg::trace_byte_s out_byte,
    input wire logic out_ready
);
    import isync_pkg::*;

    logic [31:0] main_trace_control_register;
    logic [31:0] context_identifier;
    logic [7:0] pkt_count;
    form_e last_form;
    logic [7:0] buf_mem [0:PKT_MAX-1];
    logic [7:0] next_buf [0:PKT_MAX-1];
    logic [4:0] len;
    logic [4:0] next_len;
    logic [4:0] idx;
    form_e next_form;
    logic take;
    logic wb_hit;
    logic [1:0] ctx_count;

    assign take = ce && req_valid && req_ready;
    assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign ctx_count = main_trace_control_register[CTRL_CTX_HI:CTRL_CTX_LO];

    // Bytes needed for a compressed address against a reference
    function automatic logic [2:0] comp_len(input logic [31:0] a, input logic [31:0] r);
        if (a[31:28] != r[31:28]) begin
            comp_len = 3'd5;
        end else if (a[27:21] != r[27:21]) begin
            comp_len = 3'd4;
        end else if (a[20:14] != r[20:14]) begin
            comp_len = 3'd3;
        end else if (a[13:7] != r[13:7]) begin
            comp_len = 3'd2;
        end else begin
            comp_len = 3'd1;
        end
    endfunction

    // Bytes needed for a cycle count, seven bits per byte
    function automatic logic [2:0] cnt_len(input logic [31:0] c);
        if (c[31:28] != 4'h0) begin
            cnt_len = 3'd5;
        end else if (c[27:21] != 7'h00) begin
            cnt_len = 3'd4;
        end else if (c[20:14] != 7'h00) begin
            cnt_len = 3'd3;
        end else if (c[13:7] != 7'h00) begin
            cnt_len = 3'd2;
        end else begin
            cnt_len = 3'd1;
        end
    endfunction

    // Assemble the whole packet in one go when a request is taken
    always_comb begin
        logic load_store_in_progress_form;
        logic split;
        logic with_cc;
        logic bit0;
        logic [2:0] nc;
        logic [2:0] na;
        logic [31:0] full_addr;
        int n;
        load_store_in_progress_form = 1'b0;
        split = 1'b0;
        with_cc = 1'b0;
        bit0 = 1'b0;
        nc = 3'd0;
        na = 3'd0;
        full_addr = 32'h0000_0000;
        n = 0;
        for (int i = 0; i < PKT_MAX; i++) begin
            next_buf[i] = 8'h00;
        end
        // Mid-access start forms are only for trace start, never periodic
        if (req.reason != REASON_PERIODIC && req.mid_data) begin
            load_store_in_progress_form = req.cur_executing;
            split = !req.cur_executing && req.other_retired;
        end
        // Cycle-accurate non-periodic packets embed the count
        with_cc = main_trace_control_register[CTRL_CYC_ACC_BIT] && req.reason != REASON_PERIODIC;
        full_addr = (load_store_in_progress_form || split) ? req.data_addr : req.cur_addr;
        next_buf[n] = with_cc ? HDR_SYNC_CC : HDR_SYNC;
        n++;
        if (with_cc) begin
            // Overflow counts are sent anyway; the receiver discards them
            nc = cnt_len(req.cycle_count);
            for (int k = 0; k < 5; k++) begin
                if (k < int'(nc)) begin
                    next_buf[n] = {(k < int'(nc) - 1), 7'(req.cycle_count >> (7 * k))};
                    if (k == 4) begin
                        next_buf[n] = {4'h0, req.cycle_count[31:28]};
                    end
                    n++;
                end
            end
        end
        for (int k = 0; k < 4; k++) begin
            if (k < int'({1'b0, ctx_count}) + (ctx_count == 2'd3 ? 1 : 0)) begin
                next_buf[n] = 8'(context_identifier >> (8 * k));
                n++;
            end
        end
        next_buf[n] = {load_store_in_progress_form, req.reason, req.bytecode, req.nonsecure,
            req.alt_isa & main_trace_control_register[CTRL_ALT_EN_BIT],
            req.hyp & main_trace_control_register[CTRL_HYP_EN_BIT], 1'b1};
        n++;
        // Bytecode state has byte alignment, so bit 0 is a real address bit
        bit0 = req.bytecode ? full_addr[0] : req.halfword;
        next_buf[n] = {full_addr[7:1], bit0};
        next_buf[n + 1] = full_addr[15:8];
        next_buf[n + 2] = full_addr[23:16];
        next_buf[n + 3] = full_addr[31:24];
        n += 4;
        if (load_store_in_progress_form || split) begin
            // Branch-style compression against the data instruction address
            na = comp_len(req.cur_addr, req.data_addr);
            if (load_store_in_progress_form && req.ns_changed) begin
                na = 3'd6;
            end
            for (int k = 0; k < 6; k++) begin
                if (k < int'(na)) begin
                    unique case (k)
                        0: next_buf[n] = {1'b0, req.cur_addr[6:1], 1'b1};
                        1: next_buf[n] = {1'b0, req.cur_addr[13:7]};
                        2: next_buf[n] = {1'b0, req.cur_addr[20:14]};
                        3: next_buf[n] = {1'b0, req.cur_addr[27:21]};
                        4: next_buf[n] = {4'h0, req.cur_addr[31:28]};
                        default: next_buf[n] = {2'h0, req.nonsecure, 5'h00};
                    endcase
                    next_buf[n][7] = (k < int'(na) - 1);
                    n++;
                end
            end
        end
        next_len = 5'(n);
        next_form = load_store_in_progress_form ? FORM_LOAD_STORE_IN_PROGRESS_FORM : (split ? FORM_PLAIN_BRANCH : FORM_PLAIN);
    end

    // Packet store and read index
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            len <= 5'd0;
            idx <= 5'd0;
            for (int i = 0; i < PKT_MAX; i++) begin
                buf_mem[i] <= 8'h00;
            end
        end else if (ce) begin
            if (take) begin
                len <= next_len;
                idx <= 5'd0;
                for (int i = 0; i < PKT_MAX; i++) begin
                    buf_mem[i] <= next_buf[i];
                end
            end else if (idx < len && (!out_valid || out_ready)) begin
                idx <= idx + 5'd1;
            end
        end
    end

    // Output byte stage; a stalled sink holds the byte and the whole packet
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_valid <= 1'b0;
            out_byte <= '0;
        end else if (ce) begin
            if (!take && idx < len && (!out_valid || out_ready)) begin
                out_valid <= 1'b1;
                out_byte.data <= buf_mem[idx];
                out_byte.last <= (idx == len - 5'd1);
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
        end
    end

    // Ready only when the previous packet has fully left
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req_ready <= 1'b1;
        end else if (ce) begin
            if (take) begin
                req_ready <= 1'b0;
            end else if (idx == len && out_valid && out_ready && out_byte.last) begin
                req_ready <= 1'b1;
            end
        end
    end

    // Packet counter and last form for status
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pkt_count <= 8'h00;
            last_form <= FORM_NONE;
        end else if (ce && take) begin
            pkt_count <= pkt_count + 8'h01;
            last_form <= next_form;
        end
    end

    // Register writes honour byte lanes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            main_trace_control_register <= CTRL_RESET;
            context_identifier <= CTXID_RESET;
        end else if (ce && wb_hit && wb_we_i) begin
            for (int b = 0; b < 4; b++) begin
                if (wb_sel_i[b] && wb_adr_i == CTRL_OFS) begin
                    main_trace_control_register[8 * b +: 8] <= wb_dat_i[8 * b +: 8];
                end
                if (wb_sel_i[b] && wb_adr_i == CTXID_OFS) begin
                    context_identifier[8 * b +: 8] <= wb_dat_i[8 * b +: 8];
                end
            end
        end
    end

    // One-cycle registered ack; unmapped reads return zero, writes are dropped
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (ce) begin
            wb_ack_o <= wb_hit;
            wb_dat_o <= 32'h0000_0000;
            if (wb_hit && !wb_we_i) begin
                unique case (wb_adr_i)
                    CTRL_OFS: wb_dat_o <= main_trace_control_register;
                    CTXID_OFS: wb_dat_o <= context_identifier;
                    STATUS_OFS: begin
                        wb_dat_o[STAT_BUSY_BIT] <= !req_ready;
                        wb_dat_o[STAT_FORM_HI:STAT_FORM_LO] <= last_form;
                        wb_dat_o[STAT_CNT_HI:STAT_CNT_LO] <= pkt_count;
                    end
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule

//--- src/isync_pkg.sv
// Shared constants and carrier types for the instruction-sync packet builder
package isync_pkg;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] CTXID_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    // Control register fields
    localparam int CTRL_CYC_ACC_BIT = 0;
    localparam int CTRL_ALT_EN_BIT = 1;
    localparam int CTRL_HYP_EN_BIT = 2;
    localparam int CTRL_CTX_LO = 14;
    localparam int CTRL_CTX_HI = 15;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] CTXID_RESET = 32'h0000_0000;
    // Status register fields
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_FORM_LO = 1;
    localparam int STAT_FORM_HI = 2;
    localparam int STAT_CNT_LO = 8;
    localparam int STAT_CNT_HI = 15;
    // Header bytes
    localparam logic [7:0] HDR_SYNC = 8'h08;
    localparam logic [7:0] HDR_SYNC_CC = 8'h70;
    // Reason codes
    localparam logic [1:0] REASON_PERIODIC = 2'h0;
    localparam logic [1:0] REASON_TRACE_ON = 2'h1;
    localparam logic [1:0] REASON_OVERFLOW = 2'h2;
    localparam logic [1:0] REASON_DEBUG_EXIT = 2'h3;
    // Largest packet: header, 5 count, 4 context, info, 4 address, 6 compressed
    localparam int PKT_MAX = 21;

    // Which form went out last
    typedef enum logic [1:0] {
        FORM_NONE,
        FORM_PLAIN,
        FORM_PLAIN_BRANCH,
        FORM_LOAD_STORE_IN_PROGRESS_FORM
    } form_e;

    // One sync request from the trace sequencer
    typedef struct packed {
        logic [1:0] reason;
        logic mid_data;
        logic cur_executing;
        logic other_retired;
        logic bytecode;
        logic halfword;
        logic alt_isa;
        logic nonsecure;
        logic ns_changed;
        logic hyp;
        logic [31:0] cur_addr;
        logic [31:0] data_addr;
        logic [31:0] cycle_count;
    } sync_req_s;

    // One byte of trace output
    typedef struct packed {
        logic [7:0] data;
        logic last;
    } trace_byte_s;
endpackage

//--- verification/isync_asserts.sv
// Port-level checks for the sync packet builder
`timescale 1ns/1ps
module isync_asserts (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic out_valid,
    input wire isync_pkg::trace_byte_s out_byte,
    input wire logic out_ready
);
    import isync_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Accepted bus access and accepted sync request
    sequence s_wb_take; ce && wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence s_req_take; ce && req_valid && req_ready; endsequence
    // Bus answers one cycle after taking, for one cycle only, data zero otherwise
    property p_ack_next; s_wb_take ##1 ce |-> wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("bus access not acked");
    property p_ack_once; ce && wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack held too long");
    property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
    // One packet at a time; a taken request starts output promptly
    property p_busy; s_req_take |=> !req_ready; endproperty
    a_busy: assert property (p_busy) else $error("still ready after take");
    property p_first; s_req_take |-> ##[1:2] out_valid; endproperty
    a_first: assert property (p_first) else $error("no first byte");
    property p_head; $rose(out_valid) |-> out_byte.data == HDR_SYNC || out_byte.data == HDR_SYNC_CC; endproperty
    a_head: assert property (p_head) else $error("bad header byte");
    // A stalled byte must not change under the sink
    property p_hold; ce && out_valid && !out_ready |=> out_valid && $stable(out_byte); endproperty
    a_hold: assert property (p_hold) else $error("byte changed while stalled");
    property p_done; ce && out_valid && out_ready && out_byte.last |-> ##[1:2] req_ready; endproperty
    a_done: assert property (p_done) else $error("not ready after last byte");
endmodule

//--- verification/trace_sink.sv
// Trace capture partner: accepts bytes every other cycle and keeps them in order
`timescale 1ns/1ps
module trace_sink (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic out_valid,
    input wire isync_pkg::trace_byte_s out_byte,
    output logic out_ready
);
    import isync_pkg::*;
    trace_byte_s q[$];
    // Alternate ready so every packet also sees stalls
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_ready <= 1'b0;
        end else begin
            out_ready <= ~out_ready;
        end
    end
    // Bytes kept raw; the bench compares them byte by byte against its expected encoding
    always @(posedge clk) begin
        if (out_valid && out_ready) begin
            q.push_back(out_byte);
        end
    end
endmodule

//--- verification/tb_top.sv
// Self-checking bench for the sync packet builder
`timescale 1ns/1ps
module tb_top;
    import isync_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, req_valid = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd, ctrl_v = 32'h0, ctx_v = 32'h4433_2211;
    logic wb_ack_o, req_ready, out_valid, out_ready;
    sync_req_s req = '0;
    trace_byte_s out_byte;
    logic [7:0] exp_q[$];
    int error_cnt = 0, check_count = 0, npkt = 0;
    always #50 clk = ~clk;
    instr_sync_packet_builder u_dut (.clk, .rst_n, .ce(1'b1), .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .req_valid, .req, .req_ready, .out_valid,
        .out_byte, .out_ready);
    trace_sink u_sink (.clk, .rst_n, .out_valid, .out_byte, .out_ready);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Classic single bus cycle; read data taken at the ack edge
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clk); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    // Expected packet up to the full address
    task automatic build(input sync_req_s r);
        logic [31:0] v, a;
        logic load_store_in_progress_form, more;
        load_store_in_progress_form = r.mid_data && r.cur_executing && r.reason != REASON_PERIODIC;
        v = r.cycle_count;
        // Data address only for the trace-start mid-access forms; periodic keeps the current address
        a = (load_store_in_progress_form || (r.mid_data && !r.cur_executing && r.other_retired && r.reason != REASON_PERIODIC)) ?
            r.data_addr : r.cur_addr;
        exp_q.delete();
        exp_q.push_back((ctrl_v[0] && r.reason != REASON_PERIODIC) ? HDR_SYNC_CC : HDR_SYNC);
        for (int i = 0; i < 5 && exp_q[0] == HDR_SYNC_CC; i++) begin
            more = i < 4 && v[31:7] != 0;
            exp_q.push_back(i == 4 ? {4'h0, v[3:0]} : {more, v[6:0]});
            v = v >> 7;
            if (!more) break;
        end
        for (int i = 0; i < (ctrl_v[15:14] == 2'h3 ? 4 : ctrl_v[15:14]); i++) exp_q.push_back(ctx_v[8*i +: 8]);
        exp_q.push_back({load_store_in_progress_form, r.reason, r.bytecode, r.nonsecure, r.alt_isa & ctrl_v[1], r.hyp & ctrl_v[2], 1'b1});
        exp_q.push_back({a[7:1], r.bytecode ? a[0] : r.halfword});
        for (int i = 1; i < 4; i++) exp_q.push_back(a[8*i +: 8]);
    endtask
    // Hand over one request, wait for the packet, compare n bytes (0: whole packet)
    task automatic send(input sync_req_s r, input int n);
        build(r);
        @(posedge clk);
        u_sink.q.delete();
        req_valid <= 1'b1;
        req <= r;
        do @(posedge clk); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        do @(posedge clk); while (req_ready !== 1'b1 || u_sink.q.size() == 0);
        npkt++;
        if (n == 0) begin
            chk(u_sink.q.size(), exp_q.size());
            chk(u_sink.q[$].last, 1'b1);
            n = exp_q.size();
        end
        for (int i = 0; i < n; i++) chk(u_sink.q[i].data, exp_q[i]);
    endtask
    task automatic conclude();
        $display("checks=%0d errors=%0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Watchdog: whole run needs a few hundred cycles
    initial begin
        #2000000;
        error_cnt++;
        conclude();
    end
    initial begin
        sync_req_s r;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        wb(1'b0, CTRL_OFS, 32'h0);
        chk(rd, CTRL_RESET);
        wb(1'b1, CTXID_OFS, ctx_v);
        wb(1'b0, CTXID_OFS, 32'h0);
        chk(rd, ctx_v);
        // Byte-lane write touches only the selected lane
        wb_sel_i <= 4'h1;
        wb(1'b1, CTXID_OFS, 32'hffff_ffaa);
        wb_sel_i <= 4'hf;
        wb(1'b0, CTXID_OFS, 32'h0);
        chk(rd, {ctx_v[31:8], 8'haa});
        wb(1'b1, CTXID_OFS, ctx_v);
        wb(1'b1, STATUS_OFS, 32'hffff_ffff);
        wb(1'b0, STATUS_OFS, 32'h0);
        chk(rd, 32'h0);
        wb(1'b0, 8'h0c, 32'h0);
        chk(rd, 32'h0);
        $display("test registers done");
        // Every context count and reason, flag enables toggled
        for (int k = 0; k < 4; k++) begin
            ctrl_v = {16'h0, k[1:0], 11'h0, k[0], ~k[0], 1'b0};
            wb(1'b1, CTRL_OFS, ctrl_v);
            wb(1'b0, CTRL_OFS, 32'h0);
            chk(rd & 32'h0000_c007, ctrl_v);
            r = '0;
            r.reason = k[1:0];
            r.bytecode = k[0];
            r.halfword = 1'b1;
            r.alt_isa = ~k[0];
            r.hyp = 1'b1;
            r.nonsecure = k[1];
            r.cur_addr = 32'h8765_4321 + k;
            send(r, 0);
        end
        $display("test plain done");
        // Cycle-accurate: count bytes of 1, 2 and 5 lengths, none when periodic
        ctrl_v = 32'h0000_4001;
        wb(1'b1, CTRL_OFS, ctrl_v);
        for (int k = 0; k < 4; k++) begin
            r = '0;
            r.reason = k[1:0];
            r.halfword = k[0];
            r.cur_addr = 32'h0123_4567;
            r.cycle_count = k == 1 ? 32'h85 : (k == 2 ? 32'hf234_5678 : 32'h7f);
            send(r, 0);
        end
        $display("test count done");
        // Load/store form with and without a security change
        ctrl_v = 32'h0000_0006;
        wb(1'b1, CTRL_OFS, ctrl_v);
        for (int k = 0; k < 2; k++) begin
            r = '0;
            r.reason = REASON_TRACE_ON;
            r.mid_data = 1'b1;
            r.cur_executing = 1'b1;
            r.ns_changed = k[0];
            r.data_addr = 32'h0000_1000;
            r.cur_addr = 32'h0000_1010;
            send(r, 6);
            chk(u_sink.q.size() > 6 && u_sink.q.size() <= 11 + k, 1'b1);
            chk(u_sink.q.size(), k ? 12 : 7);
            chk(u_sink.q[6].data, k ? 8'h91 : 8'h11);
            chk(u_sink.q[u_sink.q.size() - 1].data, k ? 8'h00 : 8'h11);
        end
        wb(1'b0, STATUS_OFS, 32'h0);
        chk({rd[15:8], rd[2:1]}, {npkt[7:0], 2'h3});
        r.reason = REASON_PERIODIC;
        send(r, 0);
        r.reason = REASON_DEBUG_EXIT;
        r.cur_executing = 1'b0;
        r.other_retired = 1'b1;
        send(r, 6);
        chk(u_sink.q.size() > 6, 1'b1);
        chk(u_sink.q.size(), 7);
        chk(u_sink.q[6].data, 8'h11);
        wb(1'b0, STATUS_OFS, 32'h0);
        chk(rd[2:1], 2'h2);
        $display("test load store done");
        conclude();
    end
endmodule
bind instr_sync_packet_builder isync_asserts u_chk (.clk, .rst_n, .ce, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
    .wb_dat_o, .req_valid, .req_ready, .out_valid, .out_byte, .out_ready);
